// File: hdl/hrd_decode.sv
// What this block does
// - hints retire changing nothing but pc and performance counters
// - acting on hint contents is optional; core may ignore them
// - base computational instructions with zero destination, except the canonical nop, fall in hint space
// - barriers with zero mode and an empty set are hints
// - register add hint may run as add with discarded zero write
// - barrier hint with empty prior set imposes no ordering
// - immediate sum to zero is hint unless source and immediate both zero
// - listed zero-destination forms and barrier hints are standard-reserved hints
// - zero add with sources 2 to 5 decode as nontemporal hints
// - zero barrier, writes-only prior set, empty later set is spin-wait
// - zero-destination set-less-than and immediate shifts form custom hint space
// - custom hint space has its own flag, apart from standard ones
// - reduced variant has sixteen registers; register zero reads zero
// - reduced variant: fields naming registers 16 to 31 are reserved
// - reduced variant decodes exactly like the full set otherwise
// - extensions of the full set are accepted in the reduced variant
// - reserved barrier settings run as full barriers ordering all sets; rd and rs1 ignored
`include "hrd_params.svh"
`default_nettype none
module hrd_decode
    import hrd_pkg::*;
#(
    parameter int NUM_REGS = `HRD_NUM_REGS,
    parameter int XLEN = `HRD_XLEN
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire hrd_wb_t i_wb,
    output logic o_valid,
    output hrd_class_t o_class,
    output logic o_illegal,
    output logic o_rd_we,
    output logic [4:0] o_rd_idx,
    output hrd_fence_t o_fence,
    output logic [XLEN-1:0] o_rs_a_data,
    output logic [XLEN-1:0] o_rs_b_data,
    output logic [31:0] o_hint_count
);

    logic [6:0] opc;
    logic [4:0] rd;
    logic [2:0] f3;
    logic [4:0] rsa;
    logic [4:0] rsb;
    logic [6:0] f7;
    logic [11:0] imm;
    logic [3:0] fm;
    logic [3:0] pred;
    logic [3:0] succ;
    logic rd_zero;
    logic use_rd;
    logic use_rsa;
    logic use_rsb;
    logic rd_oor;
    logic rsa_oor;
    logic rsb_oor;
    logic writes_rd;
    logic is_fence;
    hrd_class_t class_next;
    hrd_fence_t fence_next;
    logic illegal_next;
    logic any_hint;
    hrd_wb_t wb_gated;
    logic [31:0] instr_reg;

    assign opc = i_instr[`HRD_OPC_MSB:`HRD_OPC_LSB];
    assign rd = i_instr[`HRD_RD_MSB:`HRD_RD_LSB];
    assign f3 = i_instr[`HRD_F3_MSB:`HRD_F3_LSB];
    assign rsa = i_instr[`HRD_RSA_MSB:`HRD_RSA_LSB];
    assign rsb = i_instr[`HRD_RSB_MSB:`HRD_RSB_LSB];
    assign f7 = i_instr[`HRD_F7_MSB:`HRD_F7_LSB];
    assign imm = i_instr[`HRD_IMM_MSB:`HRD_IMM_LSB];
    assign fm = i_instr[`HRD_FM_MSB:`HRD_FM_LSB];
    assign pred = i_instr[`HRD_PRED_MSB:`HRD_PRED_LSB];
    assign succ = i_instr[`HRD_SUCC_MSB:`HRD_SUCC_LSB];
    assign rd_zero = (rd == `HRD_ZERO_REG);
    assign is_fence = (opc == `HRD_OPC_MISC_MEM) && (f3 == `HRD_F3_FENCE);

    // which register fields an encoding really uses; barrier fields are ignored
    always_comb
    begin
        use_rd = 1'b0;
        use_rsa = 1'b0;
        use_rsb = 1'b0;
        case (opc)
            `HRD_OPC_LUI, `HRD_OPC_PC_UPPER_SUM_OP, `HRD_OPC_JAL:
            begin
                use_rd = 1'b1;
            end
            `HRD_OPC_OP_IMM, `HRD_OPC_LOAD, `HRD_OPC_JALR:
            begin
                use_rd = 1'b1;
                use_rsa = 1'b1;
            end
            `HRD_OPC_OP:
            begin
                use_rd = 1'b1;
                use_rsa = 1'b1;
                use_rsb = 1'b1;
            end
            `HRD_OPC_STORE, `HRD_OPC_BRANCH:
            begin
                use_rsa = 1'b1;
                use_rsb = 1'b1;
            end
            `HRD_OPC_SYSTEM:
            begin
                // upper csr forms carry an immediate in the source field
                use_rd = (f3 != 3'h0);
                use_rsa = (f3 != 3'h0) && !f3[2];
            end
            default:
            begin
                // extension opcodes decode as in the full set
                use_rd = 1'b0;
            end
        endcase
    end

    hrd_reg_range #(
        .NUM_REGS(NUM_REGS)
    ) u_rd_range (
        .i_field(rd),
        .i_used(use_rd),
        .o_out_of_range(rd_oor)
    );

    hrd_reg_range #(
        .NUM_REGS(NUM_REGS)
    ) u_rsa_range (
        .i_field(rsa),
        .i_used(use_rsa),
        .o_out_of_range(rsa_oor)
    );

    hrd_reg_range #(
        .NUM_REGS(NUM_REGS)
    ) u_rsb_range (
        .i_field(rsb),
        .i_used(use_rsb),
        .o_out_of_range(rsb_oor)
    );

    // hint classification; standard and custom spaces never overlap
    always_comb
    begin
        class_next = '0;
        class_next.ntl = nontemporal_none;
        case (opc)
            `HRD_OPC_LUI, `HRD_OPC_PC_UPPER_SUM_OP:
            begin
                class_next.hint_std = rd_zero;
            end
            `HRD_OPC_OP_IMM:
            begin
                if (rd_zero)
                begin
                    case (f3)
                        `HRD_F3_ADD:
                        begin
                            class_next.hint_std = (rsa != `HRD_ZERO_REG) || (imm != 12'h000);
                            class_next.canon_nop = (rsa == `HRD_ZERO_REG) && (imm == 12'h000);
                        end
                        `HRD_F3_XOR, `HRD_F3_OR, `HRD_F3_AND:
                        begin
                            class_next.hint_std = 1'b1;
                        end
                        `HRD_F3_SLT, `HRD_F3_SET_LESS_UNSIGNED_REG_OP:
                        begin
                            class_next.hint_custom = 1'b1;
                        end
                        `HRD_F3_SLL:
                        begin
                            class_next.hint_custom = (f7 == `HRD_F7_BASE);
                        end
                        default:
                        begin
                            class_next.hint_custom = (f7 == `HRD_F7_BASE) || (f7 == `HRD_F7_ALT);
                        end
                    endcase
                end
            end
            `HRD_OPC_OP:
            begin
                if (rd_zero && f7 == `HRD_F7_BASE)
                begin
                    case (f3)
                        `HRD_F3_SLT, `HRD_F3_SET_LESS_UNSIGNED_REG_OP:
                        begin
                            class_next.hint_custom = 1'b1;
                        end
                        default:
                        begin
                            class_next.hint_std = 1'b1;
                        end
                    endcase
                    if (f3 == `HRD_F3_ADD && rsa == `HRD_ZERO_REG)
                    begin
                        case (rsb)
                            `HRD_NONTEMPORAL_PRIVATE_L1_SRC: class_next.ntl = nontemporal_private_l1;
                            `HRD_NONTEMPORAL_PRIVATE_ALL_SRC: class_next.ntl = nontemporal_private_all;
                            `HRD_NONTEMPORAL_SHARED_L1_SRC: class_next.ntl = nontemporal_shared_l1;
                            `HRD_NONTEMPORAL_EVERYWHERE_SRC: class_next.ntl = nontemporal_everywhere;
                            default: class_next.ntl = nontemporal_none;
                        endcase
                    end
                end
                else if (rd_zero && f7 == `HRD_F7_ALT)
                begin
                    class_next.hint_std = (f3 == `HRD_F3_ADD) || (f3 == `HRD_F3_SR);
                end
            end
            `HRD_OPC_MISC_MEM:
            begin
                if (is_fence && fm == `HRD_FM_NORMAL &&
                    (pred == `HRD_SET_EMPTY || succ == `HRD_SET_EMPTY))
                begin
                    class_next.hint_std = 1'b1;
                    class_next.pause = rd_zero && (rsa == `HRD_ZERO_REG) &&
                        (pred == `HRD_SET_W_ONLY) && (succ == `HRD_SET_EMPTY);
                end
            end
            default:
            begin
                class_next.hint_std = 1'b0;
            end
        endcase
    end

    assign any_hint = class_next.hint_std || class_next.hint_custom;

    // hints win over the high-register reservation
    assign illegal_next = (rd_oor || rsa_oor || rsb_oor) && !any_hint;

    // a hint is executed as its plain form; its zero-register write is dropped
    assign writes_rd = use_rd && !rd_zero && !illegal_next;

    // ordering: hint barriers order nothing, reserved settings act as full normal
    always_comb
    begin
        fence_next = '0;
        if (is_fence && !class_next.hint_std)
        begin
            fence_next.order = 1'b1;
            if (fm == `HRD_FM_NORMAL)
            begin
                fence_next.pred = pred;
                fence_next.succ = succ;
            end
            else
            begin
                // treating any nonzero mode as a conservative full barrier is always safe
                fence_next.pred = `HRD_SET_ALL;
                fence_next.succ = `HRD_SET_ALL;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_valid <= 1'b0;
            instr_reg <= '0;
        end
        else
        begin
            o_valid <= i_instr_valid;
            instr_reg <= i_instr;
        end
    end

    // hint contents only tag the output; nothing downstream depends on them
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_class <= '0;
            o_illegal <= 1'b0;
        end
        else if (i_instr_valid)
        begin
            o_class <= class_next;
            o_illegal <= illegal_next;
        end
        else
        begin
            o_class <= '0;
            o_illegal <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_rd_we <= 1'b0;
            o_rd_idx <= '0;
            o_fence <= '0;
        end
        else
        begin
            o_rd_we <= i_instr_valid && writes_rd;
            o_rd_idx <= rd;
            o_fence <= i_instr_valid ? fence_next : '0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_hint_count <= '0;
        end
        else if (i_instr_valid && any_hint)
        begin
            o_hint_count <= o_hint_count + 32'h0000_0001;
        end
    end

    // late writes to register zero are dropped even if the pipeline asks
    always_comb
    begin
        wb_gated = i_wb;
        wb_gated.we = i_wb.we && (i_wb.idx != `HRD_ZERO_REG);
    end

    hrd_regfile #(
        .NUM_REGS(NUM_REGS),
        .XLEN(XLEN)
    ) u_regfile (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_wb(wb_gated),
        .i_rd_a_idx(rsa),
        .i_rd_b_idx(rsb),
        .o_rd_a_data(o_rs_a_data),
        .o_rd_b_data(o_rs_b_data)
    );

    default clocking dcb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    hint_no_write_a:
    assert property (o_valid && (o_class.hint_std || o_class.hint_custom) |-> !o_rd_we)
        else $error("hint produced a register write");

    valid_follows_a:
    assert property (i_instr_valid |=> o_valid ##0 (instr_reg == $past(i_instr)))
        else $error("decode result not one cycle after request");

    zero_dest_op_a:
    assert property (o_valid && instr_reg[6:0] == `HRD_OPC_OP && instr_reg[11:7] == 5'h00
                     && instr_reg[31:25] == `HRD_F7_BASE
                     |-> o_class.hint_std || o_class.hint_custom)
        else $error("zero destination register op not in hint space");

    immediate_sum_op_nop_a:
    assert property (o_valid && instr_reg[6:0] == `HRD_OPC_OP_IMM && instr_reg[14:7] == 8'h00
                     |-> (o_class.canon_nop == (instr_reg[31:15] == 17'h00000))
                     && (o_class.hint_std != o_class.canon_nop))
        else $error("immediate sum nop and hint misclassified");

    ntl_decode_a:
    assert property (o_valid && instr_reg[6:0] == `HRD_OPC_OP && instr_reg[19:7] == 13'h0000
                     && instr_reg[31:25] == 7'h00 && instr_reg[24:20] == 5'h03
                     |-> o_class.ntl == nontemporal_private_all)
        else $error("nontemporal hint mis-decoded");

    pause_decode_a:
    assert property (o_valid && instr_reg == 32'h0100_000f |-> o_class.pause && !o_fence.order)
        else $error("spin-wait hint mis-decoded");

    fence_hint_order_a:
    assert property (o_valid && o_class.hint_std && o_fence.order |-> 1'b0)
        else $error("barrier hint imposed ordering");

    reserved_fence_a:
    assert property (i_instr_valid && is_fence && fm != `HRD_FM_NORMAL
                     |=> o_fence.order && o_fence.pred == 4'hf && o_fence.succ == 4'hf)
        else $error("reserved barrier not run as normal barrier");

    hint_flags_apart_a:
    assert property (o_valid |-> !(o_class.hint_std && o_class.hint_custom))
        else $error("standard and custom hint flags both set");

    high_reg_illegal_a:
    assert property (i_instr_valid && opc == `HRD_OPC_STORE && rsb[4] && NUM_REGS == 16
                     |=> o_illegal)
        else $error("high register encoding not flagged");

    hint_not_illegal_a:
    assert property (o_illegal |-> !o_class.hint_std && !o_class.hint_custom)
        else $error("hint raised illegal instruction");

    zero_reg_read_a:
    assert property (o_valid && instr_reg[19:15] == 5'h00 |-> o_rs_a_data == '0)
        else $error("register zero read nonzero");

    hint_count_a:
    assert property (i_instr_valid && any_hint |=> o_hint_count == $past(o_hint_count) + 32'h1)
        else $error("hint not counted");

    cover_ntl_c: cover property (o_valid && o_class.ntl == nontemporal_shared_l1);
    cover_pause_c: cover property (o_valid && o_class.pause);
    cover_custom_c: cover property (o_valid && o_class.hint_custom ##1 o_valid && o_class.hint_std);
    cover_illegal_c: cover property (o_valid && o_illegal);

endmodule
`default_nettype wire

// File: hdl/hrd_params.svh
`ifndef HRD_PARAMS_SVH
`define HRD_PARAMS_SVH

`define HRD_XLEN 32
`define HRD_NUM_REGS 16
`define HRD_FULL_REGS 32

`define HRD_OPC_MSB 6
`define HRD_OPC_LSB 0
`define HRD_RD_MSB 11
`define HRD_RD_LSB 7
`define HRD_F3_MSB 14
`define HRD_F3_LSB 12
`define HRD_RSA_MSB 19
`define HRD_RSA_LSB 15
`define HRD_RSB_MSB 24
`define HRD_RSB_LSB 20
`define HRD_F7_MSB 31
`define HRD_F7_LSB 25
`define HRD_IMM_MSB 31
`define HRD_IMM_LSB 20
`define HRD_FM_MSB 31
`define HRD_FM_LSB 28
`define HRD_PRED_MSB 27
`define HRD_PRED_LSB 24
`define HRD_SUCC_MSB 23
`define HRD_SUCC_LSB 20

`define HRD_OPC_LUI 7'h37
`define HRD_OPC_PC_UPPER_SUM_OP 7'h17
`define HRD_OPC_OP_IMM 7'h13
`define HRD_OPC_OP 7'h33
`define HRD_OPC_MISC_MEM 7'h0f
`define HRD_OPC_LOAD 7'h03
`define HRD_OPC_STORE 7'h23
`define HRD_OPC_BRANCH 7'h63
`define HRD_OPC_JAL 7'h6f
`define HRD_OPC_JALR 7'h67
`define HRD_OPC_SYSTEM 7'h73

`define HRD_F3_ADD 3'h0
`define HRD_F3_SLL 3'h1
`define HRD_F3_SLT 3'h2
`define HRD_F3_SET_LESS_UNSIGNED_REG_OP 3'h3
`define HRD_F3_XOR 3'h4
`define HRD_F3_SR 3'h5
`define HRD_F3_OR 3'h6
`define HRD_F3_AND 3'h7
`define HRD_F3_FENCE 3'h0

`define HRD_F7_BASE 7'h00
`define HRD_F7_ALT 7'h20

`define HRD_FM_NORMAL 4'h0
`define HRD_SET_EMPTY 4'h0
`define HRD_SET_W_ONLY 4'h1
`define HRD_SET_ALL 4'hf

`define HRD_ZERO_REG 5'h00
`define HRD_NONTEMPORAL_PRIVATE_L1_SRC 5'h02
`define HRD_NONTEMPORAL_PRIVATE_ALL_SRC 5'h03
`define HRD_NONTEMPORAL_SHARED_L1_SRC 5'h04
`define HRD_NONTEMPORAL_EVERYWHERE_SRC 5'h05

`endif

// File: hdl/hrd_pkg.sv
`include "hrd_params.svh"
`default_nettype none
package hrd_pkg;

    typedef enum logic [2:0] {
        nontemporal_none,
        nontemporal_private_l1,
        nontemporal_private_all,
        nontemporal_shared_l1,
        nontemporal_everywhere
    } hrd_ntl_t;

    typedef struct packed {
        logic hint_std;
        logic hint_custom;
        logic canon_nop;
        logic pause;
        hrd_ntl_t ntl;
    } hrd_class_t;

    typedef struct packed {
        logic we;
        logic [4:0] idx;
        logic [`HRD_XLEN-1:0] data;
    } hrd_wb_t;

    typedef struct packed {
        logic order;
        logic [3:0] pred;
        logic [3:0] succ;
    } hrd_fence_t;

endpackage
`default_nettype wire

// File: hdl/hrd_reg_range.sv
`include "hrd_params.svh"
`default_nettype none
module hrd_reg_range
    import hrd_pkg::*;
#(
    parameter int NUM_REGS = `HRD_NUM_REGS
)
(
    input wire logic [4:0] i_field,
    input wire logic i_used,
    output logic o_out_of_range
);

    // only the reduced variant has fields that can fall outside the file
    assign o_out_of_range = i_used && (32'(i_field) >= NUM_REGS);

endmodule
`default_nettype wire

// File: hdl/hrd_regfile.sv
`include "hrd_params.svh"
`default_nettype none
module hrd_regfile
    import hrd_pkg::*;
#(
    parameter int NUM_REGS = `HRD_NUM_REGS,
    parameter int XLEN = `HRD_XLEN
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire hrd_wb_t i_wb,
    input wire logic [4:0] i_rd_a_idx,
    input wire logic [4:0] i_rd_b_idx,
    output logic [XLEN-1:0] o_rd_a_data,
    output logic [XLEN-1:0] o_rd_b_data
);

    localparam int IW = $clog2(NUM_REGS);

    logic [XLEN-1:0] regs_reg [NUM_REGS];
    logic wr_ok;

    // register zero is never stored, so it cannot drift from zero
    assign wr_ok = i_wb.we && (i_wb.idx != `HRD_ZERO_REG) && (32'(i_wb.idx) < NUM_REGS);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                regs_reg[i] <= '0;
            end
        end
        else if (wr_ok)
        begin
            regs_reg[i_wb.idx[IW-1:0]] <= i_wb.data;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_rd_a_data <= '0;
            o_rd_b_data <= '0;
        end
        else
        begin
            o_rd_a_data <= (i_rd_a_idx == `HRD_ZERO_REG || 32'(i_rd_a_idx) >= NUM_REGS)
                ? '0 : regs_reg[i_rd_a_idx[IW-1:0]];
            o_rd_b_data <= (i_rd_b_idx == `HRD_ZERO_REG || 32'(i_rd_b_idx) >= NUM_REGS)
                ? '0 : regs_reg[i_rd_b_idx[IW-1:0]];
        end
    end

endmodule
`default_nettype wire

// File: verif/hint_and_reduced_reg_decode_tb.sv
`default_nettype none
module hint_and_reduced_reg_decode_tb
    import hrd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] ins;
        logic [6:0] cls;
        logic ill;
        logic we;
        logic [8:0] fen;
    } hrd_row_t;

    localparam int NROWS = 47;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_instr_valid = 1'b0;
    logic [31:0] i_instr = 32'h0000_0000;
    hrd_wb_t wb;
    logic o_valid;
    hrd_class_t o_class;
    logic o_illegal;
    logic o_rd_we;
    logic [4:0] o_rd_idx;
    hrd_fence_t o_fence;
    logic [31:0] o_rs_a_data;
    logic [31:0] o_rs_b_data;
    logic [31:0] o_hint_count;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] exp_hints = 32'h0000_0000;

    // cls bits: std, custom, nop, pause, ntl[2:0]; fen bits: order, pred, succ
    hrd_row_t rows [NROWS] = '{
        '{32'h00000013, 7'h10, 1'b0, 1'b0, 9'h000},
        '{32'h00008013, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h00100013, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h12345037, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h00001017, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0050f013, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0050e013, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0050c013, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h00200033, 7'h41, 1'b0, 1'b0, 9'h000},
        '{32'h00300033, 7'h42, 1'b0, 1'b0, 9'h000},
        '{32'h00400033, 7'h43, 1'b0, 1'b0, 9'h000},
        '{32'h00500033, 7'h44, 1'b0, 1'b0, 9'h000},
        '{32'h00600033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h40208033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0020f033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0020e033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0020c033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h00209033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0020d033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h4020d033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0010a013, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h0010b013, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h00109013, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h0010d013, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h4010d013, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h0020a033, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h0020b033, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h0100000f, 7'h48, 1'b0, 1'b0, 9'h000},
        '{32'h0030000f, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0030008f, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0030800f, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0200000f, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h0330000f, 7'h00, 1'b0, 1'b0, 9'h133},
        '{32'h8330000f, 7'h00, 1'b0, 1'b0, 9'h1ff},
        '{32'h0338888f, 7'h00, 1'b0, 1'b0, 9'h133},
        '{32'h00000837, 7'h00, 1'b1, 1'b0, 9'h000},
        '{32'h0140a023, 7'h00, 1'b1, 1'b0, 9'h000},
        '{32'h00088063, 7'h00, 1'b1, 1'b0, 9'h000},
        '{32'h015a0033, 7'h40, 1'b0, 1'b0, 9'h000},
        '{32'h000fa013, 7'h20, 1'b0, 1'b0, 9'h000},
        '{32'h003100b3, 7'h00, 1'b0, 1'b1, 9'h000},
        '{32'h00500793, 7'h00, 1'b0, 1'b1, 9'h000},
        '{32'h0000086f, 7'h00, 1'b1, 1'b0, 9'h000},
        '{32'h0008a083, 7'h00, 1'b1, 1'b0, 9'h000},
        '{32'h000890f3, 7'h00, 1'b1, 1'b0, 9'h000},
        '{32'h0008d0f3, 7'h00, 1'b0, 1'b1, 9'h000},
        '{32'h02208033, 7'h00, 1'b0, 1'b0, 9'h000}
    };

    hrd_pipe_model pipe_u (.i_clk_sys(i_clk_sys), .o_wb(wb));

    hrd_decode dut_u (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_wb(wb), .o_valid(o_valid), .o_class(o_class),
        .o_illegal(o_illegal), .o_rd_we(o_rd_we), .o_rd_idx(o_rd_idx), .o_fence(o_fence),
        .o_rs_a_data(o_rs_a_data), .o_rs_b_data(o_rs_b_data), .o_hint_count(o_hint_count)
    );

    initial
    begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // valid stays high afterwards so back-to-back calls never toggle it
    task automatic decode(input logic [31:0] ins);
        i_instr_valid = 1'b1;
        i_instr = ins;
        @(negedge i_clk_sys);
    endtask

    initial
    begin
        #(100000 * 40);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_reset = 1'b0;
        for (int k = 0; k <= NROWS; k++)
        begin
            if (k > 0)
            begin
                chk({31'h0, o_valid}, 32'h1);
                chk({o_class, o_illegal, o_rd_we, o_fence}, {rows[k-1].cls, rows[k-1].ill,
                    rows[k-1].we, rows[k-1].fen});
                exp_hints = exp_hints + (rows[k-1].cls[6] | rows[k-1].cls[5]);
            end
            if (k < NROWS)
                decode(rows[k].ins);
        end
        i_instr_valid = 1'b0;
        @(negedge i_clk_sys);
        chk({o_valid, o_class, o_illegal, o_rd_we, o_fence}, 32'h0);
        chk(o_hint_count, exp_hints);
        // writes to x0 and past x15 must vanish; x15 is the top register
        pipe_u.write(0, 5'h05, 32'ha5a5_1234);
        pipe_u.write(2, 5'h00, 32'hffff_ffff);
        pipe_u.write(0, 5'h10, 32'h1111_2222);
        pipe_u.write(1, 5'h0f, 32'h0f0f_0f0f);
        decode(32'h00f280b3);
        chk({27'h0, o_rd_idx}, 32'h1);
        chk(o_rs_a_data, 32'ha5a5_1234);
        chk(o_rs_b_data, 32'h0f0f_0f0f);
        decode(32'h010000b3);
        chk(o_rs_a_data, 32'h0000_0000);
        chk(o_rs_b_data, 32'h0000_0000);
        chk({31'h0, o_illegal}, 32'h1);
        decode(32'h00028033);
        chk({o_class, o_rd_we}, {7'h40, 1'b0});
        chk(o_rs_a_data, 32'ha5a5_1234);
        // reset in mid-run with a request pending clears counts and registers
        i_reset = 1'b1;
        decode(32'h00200033);
        decode(32'h00200033);
        chk({o_valid, o_class, o_illegal, o_rd_we, o_fence}, 32'h0);
        chk(o_hint_count, 32'h0);
        i_reset = 1'b0;
        decode(32'h000280b3);
        chk(o_rs_a_data, 32'h0000_0000);
        chk({o_rd_we, o_illegal}, 32'h2);
        i_instr_valid = 1'b0;
        @(negedge i_clk_sys);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: verif/hrd_pipe_model.sv
`default_nettype none
module hrd_pipe_model
    import hrd_pkg::*;
(
    input wire logic i_clk_sys,
    output var hrd_wb_t o_wb
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_wb = '{we: 1'b0, idx: 5'h00, data: 32'h0000_0000};

    // gap lets the pipeline answer slowly, gap+1 idle cycles before the write
    task automatic write(input int gap, input logic [4:0] idx, input logic [31:0] data);
        repeat (gap + 1) @(negedge i_clk_sys);
        o_wb = '{we: 1'b1, idx: idx, data: data};
        @(negedge i_clk_sys);
        // released port shows inverted content, never the stale value
        o_wb = '{we: 1'b0, idx: ~idx, data: ~data};
    endtask
endmodule
`default_nettype wire
